/* File: design/redriver_config_loader.sv */
// configuration path: strap decode, EEPROM loader and register target
`timescale 1ns/1ps
module redriver_config_loader
    import redriver_cfg_pkg::*;
#(
    parameter logic [TIMER_W-1:0] LOAD_CYCLES = LOAD_CYCLES_DEF
) (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst,
    // strap pins, level codes 0..4; address straps are two-bit codes 0..3
    input  wire logic [2:0]            modeStrap,
    input  wire logic [1:0]            address_strap_1,
    input  wire logic [1:0]            address_strap_0,
    input  wire logic [2:0]            eq1Strap,
    input  wire logic [2:0]            eq0Strap,
    input  wire logic [2:0]            gainStrap,
    // load handshake
    input  wire logic                  loadRequestN,
    output logic                       load_complete_n,
    // two-wire bus
    input  wire logic                  sclIn,
    input  wire logic                  sdaIn,
    output link_drive_t                linkDrive,
    // channel configuration
    output chan_cfg_t [NUM_CH-1:0]     cfgOut
);
    ////////////////////////////////////////////////////////////////////////
    logic [18:0] syncA_reg;
    logic [18:0] syncB_reg;
    logic        sclPrev_reg;
    logic        sdaPrev_reg;
    logic        busBusy_reg;
    logic [2:0]  modeS;
    logic [1:0]  a1S;
    logic [1:0]  a0S;
    logic [2:0]  eq1S;
    logic [2:0]  eq0S;
    logic [2:0]  gainS;
    logic        loadReqNS;
    logic        sclS;
    logic        sdaS;
    logic        sclRise, sclFall, startSeen, stopSeen, busMode, eepromMode;

    // pins are asynchronous: two flops before anything reads them
    always_ff @(posedge clock) begin
        if (rst) begin
            syncA_reg <= '1;
            syncB_reg <= '1;
            sclPrev_reg <= 1'b1;
            sdaPrev_reg <= 1'b1;
            busBusy_reg <= 1'b0;
        end else begin
            syncA_reg <= {modeStrap, address_strap_1, address_strap_0, eq1Strap, eq0Strap,
                          gainStrap, loadRequestN, sclIn, sdaIn};
            syncB_reg <= syncA_reg;
            sclPrev_reg <= sclS;
            sdaPrev_reg <= sdaS;
            busBusy_reg <= startSeen ? 1'b1 : (stopSeen ? 1'b0 : busBusy_reg);
        end
    end
    assign {modeS, a1S, a0S, eq1S, eq0S, gainS, loadReqNS, sclS, sdaS} = syncB_reg;

    assign sclRise = sclS && !sclPrev_reg;
    assign sclFall = !sclS && sclPrev_reg;
    assign startSeen = sclS && sclPrev_reg && sdaPrev_reg && !sdaS;
    assign stopSeen = sclS && sclPrev_reg && !sdaPrev_reg && sdaS;
    assign busMode = (modeS == MODE_TARGET) || (modeS == MODE_EEPROM);
    assign eepromMode = (modeS == MODE_EEPROM);

    ////////////////////////////////////////////////////////////////////////
    ctl_state_t           ctlState_reg, ctlState_next;
    logic [CNT_W-1:0]     ctlCnt_reg, ctlCnt_next;
    logic [3:0]           ctlBit_reg, ctlBit_next;
    logic [2:0]           ctlByte_reg, ctlByte_next;
    logic [7:0]           ctlShift_reg, ctlShift_next;
    logic                 ctlFail_reg, ctlFail_next;
    logic                 ctlSdaDly_reg, ctlSdaDly_next;
    logic                 ctlReading, ctlSdaLow, ctlSclLow, ctlStore;
    logic [7:0]           txByte;

    assign ctlReading = ctlByte_reg >= FIRST_READ;
    assign txByte = (ctlByte_reg == 3'h0) ? {EEPROM_ADDR, 1'b0} :
                    (ctlByte_reg == 3'h1) ? EEPROM_WORD : {EEPROM_ADDR, 1'b1};
    // last read byte is answered with no acknowledge
    assign ctlSdaLow = (ctlState_reg == M_LOW || ctlState_reg == M_HIGH) ?
                       ((ctlBit_reg < 4'h8) ? (!ctlReading && !ctlShift_reg[7])
                                           : (ctlReading && ctlByte_reg != LAST_BYTE)) :
                       (ctlState_reg == M_START) ? (ctlCnt_reg >= SCL_LOW_CYC + SCL_HIGH_CYC) :
                       (ctlState_reg == M_STOP) ? (ctlCnt_reg < SCL_LOW_CYC + STOP_SETUP_CYC) :
                       1'b0;
    assign ctlSclLow = (ctlState_reg == M_LOW) ||
                       ((ctlState_reg == M_START || ctlState_reg == M_STOP) &&
                        ctlCnt_reg < SCL_LOW_CYC);
    assign ctlStore = ctlState_reg == M_HIGH && sclS && ctlCnt_reg == SCL_HIGH_CYC - 1'b1 &&
                      ctlBit_reg == 4'h8 && ctlReading;

    // controller walks address, word pointer, restart, sequential read
    always_comb begin
        ctlState_next = ctlState_reg;
        ctlCnt_next = ctlCnt_reg + 1'b1;
        ctlBit_next = ctlBit_reg;
        ctlByte_next = ctlByte_reg;
        ctlShift_next = ctlShift_reg;
        ctlFail_next = ctlFail_reg;
        // data moves one cycle after the clock falls, so the wire gets hold time
        ctlSdaDly_next = ctlSdaLow;
        case (ctlState_reg)
            M_IDLE: begin
                ctlCnt_next = SCL_LOW_CYC;
                ctlByte_next = 3'h0;
                ctlFail_next = 1'b0;
                // no bus traffic unless EEPROM mode requests a load
                if (eepromMode && !loadReqNS && !busBusy_reg) begin
                    ctlState_next = M_START;
                end
            end
            M_START: begin
                // start held before first clock pulse
                if (ctlCnt_reg == SCL_LOW_CYC + SCL_HIGH_CYC + START_HOLD_CYC - 1'b1) begin
                    ctlState_next = M_LOW;
                    ctlCnt_next = '0;
                    ctlBit_next = 4'h0;
                    ctlShift_next = txByte;
                end
            end
            M_LOW: begin
                if (ctlCnt_reg == SCL_LOW_CYC - 1'b1) begin
                    ctlState_next = M_HIGH;
                    ctlCnt_next = '0;
                end
            end
            M_HIGH: begin
                // stretched clock: high time counts only once the line is seen high
                ctlCnt_next = sclS ? ctlCnt_reg + 1'b1 : ctlCnt_reg;
                if (sclS && ctlCnt_reg == SCL_HIGH_CYC - 1'b1) begin
                    ctlCnt_next = '0;
                    ctlBit_next = ctlBit_reg + 1'b1;
                    ctlState_next = M_LOW;
                    if (ctlBit_reg < 4'h8) begin
                        ctlShift_next = {ctlShift_reg[6:0], sdaS};
                        // lost arbitration: back off until the bus is free
                        if (!ctlReading && ctlShift_reg[7] && !sdaS) begin
                            ctlState_next = M_WAIT;
                        end
                    end else if (!ctlReading && sdaS) begin
                        // no acknowledge ends the load as failed
                        ctlFail_next = 1'b1;
                        ctlState_next = M_STOP;
                    end else if (ctlByte_reg == LAST_BYTE) begin
                        ctlState_next = M_STOP;
                    end else begin
                        ctlByte_next = ctlByte_reg + 1'b1;
                        ctlBit_next = 4'h0;
                        ctlShift_next = (ctlByte_reg == 3'h0) ? EEPROM_WORD : 8'h00;
                        if (ctlByte_reg == 3'h1) begin
                            ctlState_next = M_START;
                        end
                    end
                end
            end
            M_STOP: begin
                if (ctlCnt_reg == SCL_LOW_CYC + STOP_SETUP_CYC - 1'b1) begin
                    ctlState_next = ctlFail_reg ? M_FAIL : M_DONE;
                end
            end
            M_WAIT: begin
                if (!busBusy_reg) begin
                    ctlState_next = M_IDLE;
                end
            end
            default: begin
                if (loadReqNS || !eepromMode) begin
                    ctlState_next = M_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ctlState_reg <= M_IDLE;
            ctlCnt_reg <= '0;
            ctlBit_reg <= 4'h0;
            ctlByte_reg <= 3'h0;
            ctlShift_reg <= 8'h00;
            ctlFail_reg <= 1'b0;
            ctlSdaDly_reg <= 1'b0;
        end else begin
            ctlState_reg <= ctlState_next;
            ctlCnt_reg <= ctlCnt_next;
            ctlBit_reg <= ctlBit_next;
            ctlByte_reg <= ctlByte_next;
            ctlShift_reg <= ctlShift_next;
            ctlFail_reg <= ctlFail_next;
            ctlSdaDly_reg <= ctlSdaDly_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    tgt_state_t  tgtState_reg, tgtState_next;
    logic [3:0]  tgtBit_reg, tgtBit_next;
    logic [1:0]  tgtByte_reg, tgtByte_next;
    logic [7:0]  tgtShift_reg, tgtShift_next;
    logic [7:0]  tgtPtr_reg, tgtPtr_next;
    logic        tgtRw_reg, tgtRw_next;
    logic        tgtSda_reg, tgtSda_next;
    logic        addrMatch, ackNow, tgtWrite;
    logic [7:0]  readByte;
    chan_cfg_t   regs_reg [NUM_CH];
    chan_cfg_t   regs_next [NUM_CH];

    logic [1:0]  address_strap_1_s, address_strap_0_s;

    // address from the two address straps
    assign addrMatch = tgtShift_reg[7:1] == {OWN_ADDR_BASE, address_strap_1_s, address_strap_0_s};
    assign address_strap_1_s = a1S;
    assign address_strap_0_s = a0S;
    assign ackNow = tgtState_reg == T_RECV && sclFall && tgtBit_reg == 4'h8 &&
                    (tgtByte_reg != 2'h0 || addrMatch);
    // data bytes after the pointer byte land in registers
    assign tgtWrite = ackNow && tgtByte_reg == 2'h2 && tgtPtr_reg < NUM_CH;
    assign readByte = (tgtPtr_reg < NUM_CH) ? regs_reg[tgtPtr_reg[1:0]] : 8'h00;

    // target runs in both bus modes, independent of the loader
    always_comb begin
        tgtState_next = tgtState_reg;
        tgtBit_next = tgtBit_reg;
        tgtByte_next = tgtByte_reg;
        tgtShift_next = tgtShift_reg;
        tgtPtr_next = tgtPtr_reg;
        tgtRw_next = tgtRw_reg;
        tgtSda_next = tgtSda_reg;
        if (!busMode || stopSeen) begin
            tgtState_next = T_IDLE;
            tgtSda_next = 1'b0;
        end else if (startSeen) begin
            tgtState_next = T_RECV;
            tgtBit_next = 4'h0;
            tgtByte_next = 2'h0;
            tgtSda_next = 1'b0;
        end else begin
            case (tgtState_reg)
                T_RECV: begin
                    if (sclRise && tgtBit_reg < 4'h8) begin
                        tgtShift_next = {tgtShift_reg[6:0], sdaS};
                        tgtBit_next = tgtBit_reg + 1'b1;
                    end
                    // acknowledge driven on the first cycle after the fall
                    if (ackNow) begin
                        tgtSda_next = 1'b1;
                        tgtState_next = T_ACK;
                        tgtByte_next = (tgtByte_reg == 2'h2) ? 2'h2 : tgtByte_reg + 1'b1;
                        if (tgtByte_reg == 2'h0) begin
                            tgtRw_next = tgtShift_reg[0];
                        end else if (tgtByte_reg == 2'h1) begin
                            tgtPtr_next = tgtShift_reg;
                        end else begin
                            tgtPtr_next = tgtPtr_reg + 1'b1;
                        end
                    end else if (sclFall && tgtBit_reg == 4'h8) begin
                        tgtState_next = T_IDLE;
                    end
                end
                T_ACK: begin
                    if (sclFall) begin
                        tgtState_next = tgtRw_reg ? T_SEND : T_RECV;
                        tgtBit_next = tgtRw_reg ? 4'h1 : 4'h0;
                        tgtSda_next = tgtRw_reg && !readByte[7];
                        tgtShift_next = {readByte[6:0], 1'b0};
                        tgtPtr_next = tgtRw_reg ? tgtPtr_reg + 1'b1 : tgtPtr_reg;
                    end
                end
                T_SEND: begin
                    // each data bit follows the fall within a few cycles
                    if (sclFall) begin
                        tgtBit_next = tgtBit_reg + 1'b1;
                        tgtSda_next = (tgtBit_reg < 4'h8) && !tgtShift_reg[7];
                        tgtShift_next = {tgtShift_reg[6:0], 1'b0};
                        tgtState_next = (tgtBit_reg < 4'h8) ? T_SEND : T_RACK;
                    end
                end
                T_RACK: begin
                    if (sclRise) begin
                        tgtState_next = sdaS ? T_IDLE : T_ACK;
                    end
                end
                default: begin
                    tgtSda_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            tgtState_reg <= T_IDLE;
            tgtBit_reg <= 4'h0;
            tgtByte_reg <= 2'h0;
            tgtShift_reg <= 8'h00;
            tgtPtr_reg <= 8'h00;
            tgtRw_reg <= 1'b0;
            tgtSda_reg <= 1'b0;
        end else begin
            tgtState_reg <= tgtState_next;
            tgtBit_reg <= tgtBit_next;
            tgtByte_reg <= tgtByte_next;
            tgtShift_reg <= tgtShift_next;
            tgtPtr_reg <= tgtPtr_next;
            tgtRw_reg <= tgtRw_next;
            tgtSda_reg <= tgtSda_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [TIMER_W-1:0]     loadTimer_reg, loadTimer_next;
    logic                   load_complete_n_next;
    chan_cfg_t [NUM_CH-1:0] cfg_next;
    chan_cfg_t              strapCfg;
    link_drive_t            drive_next;

    assign strapCfg = '{gain: strap_gain(gainS), eq: strap_eq(eq1S, eq0S)};

    always_comb begin
        regs_next = regs_reg;
        if (ctlStore) begin
            regs_next[2'(ctlByte_reg - FIRST_READ)] = ctlShift_reg;
        end
        if (tgtWrite) begin
            regs_next[tgtPtr_reg[1:0]] = tgtShift_reg;
        end
        // load time measured from the request while idle
        loadTimer_next = (ctlState_reg == M_IDLE) ? LOAD_CYCLES :
                         (loadTimer_reg != '0) ? loadTimer_reg - 1'b1 : loadTimer_reg;
        // done only after a clean load and the load time
        load_complete_n_next = !(ctlState_reg == M_DONE && loadTimer_reg == '0);
        // strap mode uses the strap decode alone
        for (int i = 0; i < NUM_CH; i++) begin
            cfg_next[i] = busMode ? regs_reg[i] : strapCfg;
        end
        drive_next = '{sclOut: 1'b0, sclOe: ctlSclLow, sdaOut: 1'b0,
                       sdaOe: ctlSdaDly_reg || tgtSda_reg};
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < NUM_CH; i++) begin
                regs_reg[i] <= RESET_CFG;
                cfgOut[i] <= RESET_CFG;
            end
            loadTimer_reg <= LOAD_CYCLES;
            load_complete_n <= 1'b1;
            linkDrive <= '0;
        end else begin
            regs_reg <= regs_next;
            cfgOut <= cfg_next;
            loadTimer_reg <= loadTimer_next;
            load_complete_n <= load_complete_n_next;
            linkDrive <= drive_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // the pin fall reaches ackNow up to three cycles late through the synchroniser
    localparam int DvBound = DATA_VALID_CYC - 3;

    sequence startBegin;
        ctlState_reg == M_START && ctlCnt_reg == SCL_LOW_CYC + SCL_HIGH_CYC;
    endsequence

    sequence startHeld;
        linkDrive.sdaOe && !linkDrive.sclOe;
    endsequence

    strap_cfg_a: assert property (!busMode ##1 !busMode |=> cfgOut[0] == $past(strapCfg))
        else $error("strap mode config not from straps");
    strap_quiet_a: assert property (!busMode |=> tgtState_reg == T_IDLE && !tgtSda_reg)
        else $error("target active outside bus modes");
    done_low_a: assert property (!load_complete_n |-> $past(ctlState_reg == M_DONE))
        else $error("done asserted without a clean load");
    fail_high_a: assert property (ctlState_reg == M_FAIL |=> load_complete_n)
        else $error("done asserted after failed load");
    load_time_a: assert property ($fell(load_complete_n) |-> $past(loadTimer_reg) == '0)
        else $error("done asserted before load time");
    high_phase_a: assert property ($rose(ctlState_reg == M_HIGH) |=> !linkDrive.sclOe [*8])
        else $error("controller clock high phase cut short");
    start_hold_a: assert property (startBegin |-> ##2 startHeld [*8])
        else $error("start hold too short");
    ack_valid_a: assert property (ackNow |-> ##[1:DvBound] linkDrive.sdaOe)
        else $error("target acknowledge late");
endmodule

/* File: inc/redriver_cfg_pkg.sv */
// constants and types for the redriver configuration loader
package redriver_cfg_pkg;
    localparam int NUM_CH = 4;
    localparam int TIMER_W = 17;
    localparam int CNT_W = 6;
    // strap levels L0..L4 are coded 0..4
    localparam logic [2:0] MODE_TARGET = 3'h2;
    localparam logic [2:0] MODE_EEPROM = 3'h3;
    localparam logic [2:0] OWN_ADDR_BASE = 3'h6;
    localparam logic [6:0] EEPROM_ADDR = 7'h50;
    localparam logic [7:0] EEPROM_WORD = 8'h00;
    localparam logic [2:0] FIRST_READ = 3'h3;
    localparam logic [2:0] LAST_BYTE = 3'h6;
    localparam logic [4:0] EQ_MAX = 5'h13;
    // timing in printed units, then cycles at the system clock
    localparam int CLK_NS = 100;
    localparam int SCL_LOW_NS = 1900;
    localparam int SCL_HIGH_NS = 1400;
    localparam int START_HOLD_NS = 1500;
    localparam int STOP_SETUP_NS = 1500;
    localparam int DATA_VALID_NS = 900;
    localparam int EEPROM_LOAD_US = 7500;
    localparam logic [CNT_W-1:0] SCL_LOW_CYC = CNT_W'(SCL_LOW_NS / CLK_NS);
    localparam logic [CNT_W-1:0] SCL_HIGH_CYC = CNT_W'(SCL_HIGH_NS / CLK_NS);
    localparam logic [CNT_W-1:0] START_HOLD_CYC = CNT_W'(START_HOLD_NS / CLK_NS);
    localparam logic [CNT_W-1:0] STOP_SETUP_CYC = CNT_W'(STOP_SETUP_NS / CLK_NS);
    localparam int DATA_VALID_CYC = DATA_VALID_NS / CLK_NS;
    localparam logic [TIMER_W-1:0] LOAD_CYCLES_DEF = TIMER_W'(EEPROM_LOAD_US * 1000 / CLK_NS);

    typedef struct packed {
        logic [2:0] gain;
        logic [4:0] eq;
    } chan_cfg_t;

    localparam chan_cfg_t RESET_CFG = '{gain: 3'h5, eq: 5'h00};

    typedef struct packed {
        logic sclOut;
        logic sclOe;
        logic sdaOut;
        logic sdaOe;
    } link_drive_t;

    typedef enum logic [2:0] {
        M_IDLE = 3'h0, M_START = 3'h1, M_LOW = 3'h3, M_HIGH = 3'h2,
        M_STOP = 3'h6, M_DONE = 3'h7, M_FAIL = 3'h5, M_WAIT = 3'h4
    } ctl_state_t;

    typedef enum logic [2:0] {
        T_IDLE = 3'h0, T_RECV = 3'h1, T_ACK = 3'h3, T_SEND = 3'h2, T_RACK = 3'h6
    } tgt_state_t;

    function automatic logic [4:0] strap_eq(input logic [2:0] l1, input logic [2:0] l0);
        logic [4:0] idx;
        idx = 5'(l1 * 5 + l0);
        return (idx > EQ_MAX) ? EQ_MAX : idx;
    endfunction

    function automatic logic [2:0] strap_gain(input logic [2:0] lvl);
        case (lvl)
            3'h0: return 3'h0;
            3'h1: return 3'h1;
            3'h2: return 3'h3;
            3'h3: return 3'h7;
            default: return 3'h5;
        endcase
    endfunction
endpackage

/* File: tb/eeprom_model.sv */
// serial EEPROM model answering the device's configuration read
`timescale 1ns/1ps
module eeprom_model (
    // bus wires and pull enable
    input  wire logic        scl,
    input  wire logic        sda,
    output logic             sdaOe,
    // stored image and refusal control
    input  wire logic [31:0] image,
    input  wire logic        refuse
);
    logic [7:0] sh;
    int         cnt;
    int         idx;
    logic       sel;
    logic       rd;
    logic       adr;
    initial begin
        sdaOe = 0;
        rd = 0;
        cnt = 0;
    end
    // start or repeated start reframes; released line floats to the pull-up
    always @(negedge sda) if (scl) begin
        {cnt, idx, rd, sdaOe} = '0;
        adr = 1;
        sel = 1;
    end
    always @(posedge scl) begin
        if (cnt < 8) sh = {sh[6:0], sda};
        cnt = cnt + 1;
    end
    // acks its own address, then serves bytes msb first
    always @(negedge scl) begin
        sdaOe = 0;
        if (cnt == 8 && adr && sh[7:1] != 7'h50) sel = 0;
        if (cnt == 8) sdaOe = sel && !rd && !refuse;
        if (cnt == 9) begin
            cnt = 0;
            if (rd) idx = idx + 1;
            if (adr && sh[0]) rd = sel;
            adr = 0;
        end
        if (rd && cnt < 8 && idx < 4) sdaOe = !image[8*idx+7-cnt];
    end
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the redriver configuration loader
`timescale 1ns/1ps
module testbench
    import redriver_cfg_pkg::*;
;
    logic                   clock, rst, loadRequestN, load_complete_n, hScl, hSda, refuse, k;
    logic [2:0]             modeStrap, eq1Strap, eq0Strap, gainStrap;
    logic [1:0]             address_strap_1, address_strap_0;
    logic [31:0]            image, seed;
    logic [7:0]             d;
    logic                   eeOe;
    link_drive_t            linkDrive;
    chan_cfg_t [NUM_CH-1:0] cfgOut;
    int                     n_fail, compares, t;
    localparam logic [TIMER_W-1:0] LoadCyc = 17'h00fa0;
    wire sclIn = !(linkDrive.sclOe | hScl);
    wire sdaIn = !(linkDrive.sdaOe | hSda | eeOe);
    redriver_config_loader #(.LOAD_CYCLES(LoadCyc)) dut (.clock, .rst, .modeStrap,
        .address_strap_1, .address_strap_0, .eq1Strap, .eq0Strap, .gainStrap, .loadRequestN,
        .load_complete_n, .sclIn, .sdaIn, .linkDrive, .cfgOut);
    eeprom_model rom (.scl(sclIn), .sda(sdaIn), .sdaOe(eeOe), .image(image), .refuse(refuse));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #5;
    endtask
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] expCfg(input logic [2:0] l1, l0, g);
        logic [4:0][2:0] gt;
        gt = {3'h5, 3'h7, 3'h3, 3'h1, 3'h0};
        return {gt[g], (l1 * 5 + l0 > 19) ? 5'h13 : 5'(l1 * 5 + l0)};
    endfunction
    // host clock phases
    // host bit: 1.5 us low, 0.8 us high keeps the external clock limits
    task automatic hbit(input logic b, output logic s);
        hSda = !b;
        cyc(7);
        hScl = 0;
        cyc(8);
        s = sdaIn;
        hScl = 1;
        cyc(8);
    endtask
    task automatic hwrite(input logic [3:0] a, input logic [7:0] r, v, output logic ack);
        logic [26:0] w;
        logic        s;
        w = {3'b110, a, 1'b0, 1'b1, r, 1'b1, v, 1'b1};
        ack = 0;
        hSda = 1;
        cyc(8);
        hScl = 1;
        cyc(8);
        for (int i = 26; i >= 0; i--) begin
            hbit(w[i], s);
            if (i % 9 == 0) ack |= s;
        end
        hSda = 1;
        cyc(7);
        hScl = 0;
        cyc(8);
        hSda = 0;
        cyc(15);
    endtask
    task automatic restart(input logic [2:0] m);
        modeStrap = m;
        rst = 1;
        cyc(16);
        rst = 0;
        cyc(8);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 0;
        forever #50 clock = ~clock;
    end
    initial begin
        {hScl, hSda, refuse, n_fail, compares} = '0;
        {eq1Strap, eq0Strap, gainStrap, address_strap_1, address_strap_0} = '0;
        {rst, loadRequestN, seed, image, modeStrap} = {2'b11, 32'h8, 32'h0, 3'h0};
        for (int i = 0; i < 4; i++) begin
            {eq1Strap, eq0Strap, gainStrap} = {3'(rnd() % 5), 3'(rnd() % 5), 3'(rnd() % 5)};
            if (i == 0) {eq1Strap, eq0Strap, gainStrap} = {3'h4, 3'h4, 3'h3};
            restart(3'h0);
            chk(cfgOut, {4{expCfg(eq1Strap, eq0Strap, gainStrap)}});
            hwrite({address_strap_1, address_strap_0}, 8'h00, 8'h00, k);
            chk({k, linkDrive}, {1'b1, 4'h0});
        end
        for (int i = 0; i < 4; i++) begin
            {address_strap_1, address_strap_0, d} = 12'(rnd());
            restart(3'h2);
            hwrite({address_strap_1, address_strap_0}, 8'(i), d, k);
            chk({k, cfgOut[i]}, {1'b0, d});
            hwrite(~{address_strap_1, address_strap_0}, 8'(i), ~d, k);
            chk({k, cfgOut[i]}, {1'b1, d});
        end
        image = rnd();
        restart(3'h3);
        // host writes before the load, so no arbitration is needed
        hwrite({address_strap_1, address_strap_0}, 8'h02, 8'h5a, k);
        chk({k, cfgOut[2]}, {1'b0, 8'h5a});
        loadRequestN = 0;
        t = 0;
        while (load_complete_n !== 1'b0 && t < 6000) begin
            cyc(1);
            t++;
        end
        // two sync flops, leaving idle and the output flop add four cycles
        chk(t >= LoadCyc + 3 && t <= LoadCyc + 5, 1);
        chk(cfgOut, image);
        loadRequestN = 1;
        cyc(8);
        chk(load_complete_n, 1);
        refuse = 1;
        loadRequestN = 0;
        cyc(LoadCyc + 100);
        chk(load_complete_n, 1);
        summarize();
    end
endmodule
